// ### design/sldc_pkg.sv
// constants, field layouts and types of the segment lcd duty and pin block
package sldc_pkg;
    // ------------------------------------------------------------------
    // register map (word indexes, byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam int unsigned IDX_W         = 16;
    localparam logic [15:0] IDX_PIN_CFG   = 16'hFFC0;
    localparam logic [15:0] IDX_CTRL      = 16'hFFC1;
    localparam logic [15:0] IDX_STATUS    = 16'hFFC2;
    localparam logic [15:0] IDX_RAM_FIRST = 16'hF740;
    localparam logic [15:0] IDX_RAM_LAST  = 16'hF77F;
    localparam logic [7:0]  PIN_CFG_RST   = 8'h00;
    localparam logic [7:0]  CTRL_RST      = 8'h80;
    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_ON_BIT   = 7;
    localparam int unsigned FRAME_W       = 4;
    localparam logic [3:0]  FRAME_SEL_MAX = 4'hA;
    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int unsigned RAM_DEPTH     = 64;
    localparam int unsigned RAM_AW        = 6;
    localparam int unsigned RAM_BITS      = 512;
    localparam int unsigned BIT_AW        = 9;
    localparam int unsigned SEG_N         = 40;
    localparam int unsigned COM_N         = 4;
    localparam int unsigned GROUP_W       = 4;
    localparam int unsigned GROUP_N       = 10;
    localparam logic [8:0]  EXP_FIRST_SEG = 9'h024;
    localparam logic [8:0]  EXP_SEGS_STAT = 9'h1DC;
    localparam logic [8:0]  EXP_SEGS_HALF = 9'h0DC;
    localparam logic [8:0]  EXP_SEGS_QUAD = 9'h05C;
    // expansion signals sit on the four highest segment pins
    localparam int unsigned PIN_LATCH     = 39;
    localparam int unsigned PIN_SHIFT     = 38;
    localparam int unsigned PIN_DATA      = 37;
    localparam int unsigned PIN_ALT       = 36;
    localparam int unsigned PH_CNT_W      = 22;
    localparam int unsigned PHASE_BASE_DEF = 2048;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DUTY_STATIC  = 2'h0,
        DUTY_HALF    = 2'h1,
        DUTY_THIRD   = 2'h2,
        DUTY_QUARTER = 2'h3
    } sldc_duty_e;

    typedef struct packed {
        sldc_duty_e duty;
        logic       common_multiplex_bit;
        logic       expansion_select_bit;
        logic [3:0] sgs;
    } sldc_pin_cfg_s;

    typedef enum logic [1:0] {
        SH_IDLE = 2'h0,
        SH_HIGH = 2'h1,
        SH_LOW  = 2'h3
    } sldc_shift_e;
endpackage : sldc_pkg

// ### design/sldc_top.sv
// segment lcd duty, common and segment pin control with display ram
`timescale 1ns/10ps
`default_nettype none

// How it works
// - duty field picks static, half, third, quarter
// - without multiplex, unused commons become ports
// - with multiplex, spare commons copy used waveforms at static and half duty
// - third duty multiplex: fourth common never selected
// - no expansion, group zero: commons are ports
// - pin configuration register resets to zero
// - 64 byte display ram, byte and word access
// - segment pins switch to ports by fours
// - display stops in standby
// - eleven selectable frame rates
// - expansion: segment_pin_40 latch clock, seg39 shift clock
// - expansion: seg38 serial data, segment_pin_37 polarity
// - expansion: 36 internal, 476/220/92 external segments
// - expansion bit turns top four pins into signals
// - group field enables groups from top down
module sldc_top #(
    parameter int unsigned PHASE_BASE = sldc_pkg::PHASE_BASE_DEF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [17:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        standby_i,
    input  wire logic [39:0] seg_port_i,
    input  wire logic [3:0]  com_port_i,
    output logic      [39:0] seg_pin_o,
    output logic      [39:0] seg_lcd_o,
    output logic      [3:0]  com_pin_o,
    output logic      [3:0]  com_lcd_o,
    output logic             lcd_m_o
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // linear ram bit of a segment in one common phase
    function automatic logic [8:0] bit_idx(input logic [8:0] seg,
                                           input logic [2:0] n,
                                           input logic [1:0] c);
        logic [11:0] p;
        p = 12'(seg) * 12'(n) + 12'(c);
        return p[8:0];
    endfunction : bit_idx

    // number of enabled segment groups counted from the top
    function automatic logic [3:0] groups_on(input logic [3:0] g);
        logic [3:0] r;
        r = 4'h0;
        if (g[3])
            r = g[0] ? 4'hA : 4'h9;
        else if (g != 4'h0)
            r = g + 4'h1;
        return r;
    endfunction : groups_on

    // ------------------------------------------------------------------
    // registers and bus decode
    // ------------------------------------------------------------------
    sldc_pkg::sldc_pin_cfg_s cfg_r;
    logic [7:0]              ctrl_r;
    logic [7:0]              ram [sldc_pkg::RAM_DEPTH];
    logic [31:0]             rdat_r;
    logic                    ack_r;
    logic [1:0]              stby_sync_r;

    wire logic [15:0] idx       = wb_adr_i[17:2];
    wire logic        req       = wb_cyc_i & wb_stb_i & ~ack_r;
    wire logic        wr        = req & wb_we_i;
    wire logic        hit_cfg   = idx == sldc_pkg::IDX_PIN_CFG;
    wire logic        hit_ctrl  = idx == sldc_pkg::IDX_CTRL;
    wire logic        hit_stat  = idx == sldc_pkg::IDX_STATUS;
    wire logic        hit_ram   = idx >= sldc_pkg::IDX_RAM_FIRST &&
                                  idx <= sldc_pkg::IDX_RAM_LAST;
    wire logic [15:0] ram_off   = idx - sldc_pkg::IDX_RAM_FIRST;
    wire logic [5:0]  ram_a     = ram_off[5:0];
    wire logic [5:0]  ram_a1    = ram_a + 6'h01;
    // upper lane reaches the partner byte only from an even index
    wire logic        pair      = wb_sel_i[1] & ~ram_a[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r  <= sldc_pkg::PIN_CFG_RST;
            ctrl_r <= sldc_pkg::CTRL_RST;
        end else if (wr & wb_sel_i[0]) begin
            if (hit_cfg)
                cfg_r <= wb_dat_i[7:0];
            if (hit_ctrl)
                ctrl_r <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr & hit_ram & wb_sel_i[0])
            ram[ram_a] <= wb_dat_i[7:0];
        if (wr & hit_ram & pair)
            ram[ram_a1] <= wb_dat_i[15:8];
    end

    // ------------------------------------------------------------------
    // display timing
    // ------------------------------------------------------------------
    logic [sldc_pkg::PH_CNT_W-1:0] ph_cnt_r;
    logic [1:0]                    phase_r;
    logic                          m_r;

    always_ff @(posedge clk_i) begin
        if (rst_i)
            stby_sync_r <= 2'h0;
        else
            stby_sync_r <= {stby_sync_r[0], standby_i};
    end

    wire logic       run      = ctrl_r[sldc_pkg::CTRL_ON_BIT] &
                                ~stby_sync_r[1];
    wire logic [3:0] fsel_raw = ctrl_r[sldc_pkg::FRAME_W-1:0];
    wire logic [3:0] fsel     = (fsel_raw > sldc_pkg::FRAME_SEL_MAX) ?
                                sldc_pkg::FRAME_SEL_MAX : fsel_raw;
    wire logic [sldc_pkg::PH_CNT_W-1:0] ph_len =
        sldc_pkg::PH_CNT_W'(PHASE_BASE) << fsel;
    wire logic       ph_end   = ph_cnt_r >= ph_len -
                                sldc_pkg::PH_CNT_W'(1);
    wire logic [2:0] n_com    = {1'b0, cfg_r.duty} + 3'h1;
    wire logic [1:0] last_ph  = cfg_r.duty;
    wire logic [1:0] next_ph  = (phase_r == last_ph) ? 2'h0 :
                                phase_r + 2'h1;

    always_ff @(posedge clk_i) begin
        if (rst_i || !run) begin
            ph_cnt_r <= '0;
            phase_r  <= 2'h0;
            m_r      <= 1'b0;
        end else if (ph_end) begin
            ph_cnt_r <= '0;
            phase_r  <= next_ph;
            if (next_ph == 2'h0)
                m_r <= ~m_r;
        end else begin
            ph_cnt_r <= ph_cnt_r + sldc_pkg::PH_CNT_W'(1);
            if (phase_r > last_ph)
                phase_r <= 2'h0;
        end
    end

    // ------------------------------------------------------------------
    // display ram as one bit vector
    // ------------------------------------------------------------------
    logic [sldc_pkg::RAM_BITS-1:0] ram_bits;

    generate
        for (genvar b = 0; b < sldc_pkg::RAM_DEPTH; b++) begin : g_flat
            assign ram_bits[b*8 +: 8] = ram[b];
        end
    endgenerate

    // ------------------------------------------------------------------
    // external expansion shifter
    // ------------------------------------------------------------------
    sldc_pkg::sldc_shift_e sh_st_r;
    logic [8:0]            exp_cnt_r;
    logic                  exp_dat_r;
    logic                  latch_r;

    wire logic [8:0] exp_segs = (cfg_r.duty == sldc_pkg::DUTY_STATIC) ?
                                sldc_pkg::EXP_SEGS_STAT :
                                (cfg_r.duty == sldc_pkg::DUTY_HALF) ?
                                sldc_pkg::EXP_SEGS_HALF :
                                sldc_pkg::EXP_SEGS_QUAD;
    wire logic       exp_on   = run & cfg_r.expansion_select_bit;
    wire logic [8:0] exp_bit  = bit_idx(sldc_pkg::EXP_FIRST_SEG + exp_cnt_r,
                                        n_com, next_ph);

    always_ff @(posedge clk_i) begin
        if (rst_i || !exp_on) begin
            sh_st_r   <= sldc_pkg::SH_IDLE;
            exp_cnt_r <= 9'h000;
            exp_dat_r <= 1'b0;
            latch_r   <= 1'b0;
        end else begin
            latch_r <= ph_end;
            if (ph_end) begin
                // data for the coming phase is latched now, start the next
                sh_st_r   <= sldc_pkg::SH_IDLE;
                exp_cnt_r <= 9'h000;
            end else begin
                case (sh_st_r)
                    sldc_pkg::SH_IDLE: begin
                        if (exp_cnt_r < exp_segs) begin
                            exp_dat_r <= ram_bits[exp_bit];
                            sh_st_r   <= sldc_pkg::SH_HIGH;
                        end
                    end
                    sldc_pkg::SH_HIGH: begin
                        sh_st_r <= sldc_pkg::SH_LOW;
                    end
                    sldc_pkg::SH_LOW: begin
                        exp_cnt_r <= exp_cnt_r + 9'h001;
                        sh_st_r   <= sldc_pkg::SH_IDLE;
                    end
                    default: begin
                        sh_st_r <= sldc_pkg::SH_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // segment pin function
    // ------------------------------------------------------------------
    wire logic [3:0] grp_cnt  = groups_on(cfg_r.sgs);
    wire logic [3:0] grp_low  = 4'(sldc_pkg::GROUP_N) - grp_cnt;
    logic [39:0]     seg_lcd;
    logic [39:0]     seg_val;

    generate
        for (genvar s = 0; s < sldc_pkg::SEG_N; s++) begin : g_seg
            localparam int unsigned GRP = s / sldc_pkg::GROUP_W;
            wire logic top = GRP == sldc_pkg::GROUP_N - 1;
            wire logic on  = (4'(GRP) >= grp_low) && grp_cnt != 4'h0;
            // top group goes to expansion even with no group enabled
            assign seg_lcd[s] = top ? (on | cfg_r.expansion_select_bit) : on;
            assign seg_val[s] = run &
                                ram_bits[bit_idx(9'(s), n_com, phase_r)];
        end
    endgenerate

    logic [39:0] seg_drive;

    always_comb begin
        seg_drive = seg_val;
        if (cfg_r.expansion_select_bit) begin
            seg_drive[sldc_pkg::PIN_LATCH] = latch_r;
            seg_drive[sldc_pkg::PIN_SHIFT] =
                sh_st_r == sldc_pkg::SH_HIGH;
            seg_drive[sldc_pkg::PIN_DATA]  = exp_dat_r;
            seg_drive[sldc_pkg::PIN_ALT]   = m_r;
        end
    end

    // ------------------------------------------------------------------
    // common pin function
    // ------------------------------------------------------------------
    wire logic   com_off = ~cfg_r.expansion_select_bit && cfg_r.sgs == 4'h0;
    logic [3:0]  com_lcd;
    logic [3:0]  com_sel;

    generate
        for (genvar c = 0; c < sldc_pkg::COM_N; c++) begin : g_com
            logic [1:0] src;
            logic       used;
            always_comb begin
                case (cfg_r.duty)
                    sldc_pkg::DUTY_STATIC: src = 2'h0;
                    // without multiplex each common keeps its own phase
                    sldc_pkg::DUTY_HALF:   src = cfg_r.common_multiplex_bit ? 2'(c / 2)
                                                           : 2'(c);
                    default:               src = 2'(c);
                endcase
            end
            assign used       = 3'(c) < n_com;
            assign com_lcd[c] = ~com_off & (used | cfg_r.common_multiplex_bit);
            // a common past the duty never matches the phase: non-select
            assign com_sel[c] = run & (src <= last_ph) &
                                (phase_r == src);
        end
    endgenerate

    // ------------------------------------------------------------------
    // registered pin outputs
    // ------------------------------------------------------------------
    logic [39:0] seg_pin_r;
    logic [39:0] seg_lcd_r;
    logic [3:0]  com_pin_r;
    logic [3:0]  com_lcd_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seg_pin_r <= '0;
            seg_lcd_r <= '0;
            com_pin_r <= 4'h0;
            com_lcd_r <= 4'h0;
        end else begin
            seg_pin_r <= (seg_lcd & seg_drive) |
                         (~seg_lcd & seg_port_i);
            seg_lcd_r <= seg_lcd;
            com_pin_r <= (com_lcd & com_sel) |
                         (~com_lcd & com_port_i);
            com_lcd_r <= com_lcd;
        end
    end

    // ------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------
    wire logic [7:0] status = {5'h00, run, m_r, 1'b0} | {6'h00, phase_r};
    logic [31:0]     rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_cfg)
            rd_mux[7:0] = cfg_r;
        else if (hit_ctrl)
            rd_mux[7:0] = ctrl_r;
        else if (hit_stat)
            rd_mux[7:0] = status;
        else if (hit_ram) begin
            rd_mux[7:0] = ram[ram_a];
            if (pair)
                rd_mux[15:8] = ram[ram_a1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= req;
            rdat_r <= (req & ~wb_we_i) ? rd_mux : 32'h0000_0000;
        end
    end

    assign wb_ack_o  = ack_r;
    assign wb_dat_o  = rdat_r;
    assign seg_pin_o = seg_pin_r;
    assign seg_lcd_o = seg_lcd_r;
    assign com_pin_o = com_pin_r;
    assign com_lcd_o = com_lcd_r;
    assign lcd_m_o   = m_r;
endmodule : sldc_top

`default_nettype wire

// ### tb/sldc_props.sv
// port-level assertions of the segment lcd duty and pin block
`timescale 1ns/10ps
`default_nettype none
module sldc_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        standby_i,
    input wire logic [39:0] seg_port_i,
    input wire logic [39:0] seg_pin_o,
    input wire logic [39:0] seg_lcd_o,
    input wire logic [3:0]  com_pin_o,
    input wire logic [3:0]  com_lcd_o,
    input wire logic        lcd_m_o
);
    logic [7:0] cfg_r;
    logic [2:0] age_r;
    logic [2:0] stb_r;
    logic       stq_r;
    // mirror of the pin config, so pin checks need no look inside
    wire        cfg_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o
                         & wb_sel_i[0]
                         & (wb_adr_i[17:2] == sldc_pkg::IDX_PIN_CFG);
    // pin checks wait out the register and standby sync latency
    wire        settled = (age_r == 3'h7) & ~standby_i;
    wire        expansion_select_bit = cfg_r[4];
    wire [3:0]  sgs = cfg_r[3:0];
    wire [3:0]  grp = sgs[3] ? 4'h9 + {3'h0, sgs[0]}
                             : sgs + {3'h0, (sgs != 4'h0) | expansion_select_bit};
    wire [39:0] seg_exp = ~(40'hFF_FFFF_FFFF >> {grp, 2'h0});
    wire [3:0]  com_exp = (!expansion_select_bit && sgs == 4'h0) ? 4'h0
                        : cfg_r[5] ? 4'hF : 4'hF >> (2'h3 - cfg_r[7:6]);
    always_ff @(posedge clk_i) begin
        stq_r <= standby_i;
        cfg_r <= rst_i ? 8'h00 : cfg_wr ? wb_dat_i[7:0] : cfg_r;
        age_r <= (rst_i | cfg_wr | (standby_i ^ stq_r)) ? 3'h0
               : age_r + {2'h0, age_r != 3'h7};
        stb_r <= !standby_i ? 3'h0 : stb_r + {2'h0, stb_r != 3'h7};
    end
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence clk_rest;
        !seg_pin_o[38] [*2];
    endsequence
    a_ack_pulse: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack is not a one cycle pulse");
    a_com_func: assert property (
        settled |-> com_lcd_o == com_exp)
        else $error("common pin function wrong");
    a_seg_groups: assert property (
        settled |-> seg_lcd_o == seg_exp)
        else $error("segment group function wrong");
    a_port_follow: assert property (
        settled && $stable(seg_lcd_o)
        |-> ((seg_pin_o ^ $past(seg_port_i)) & ~seg_lcd_o) == 40'h0)
        else $error("port pin does not follow port logic");
    a_quarter_scan: assert property (
        settled && cfg_r[7:6] == 2'h3 && com_lcd_o == 4'hF
        |-> $onehot(com_pin_o))
        else $error("quarter duty selects not one common");
    a_com_parallel: assert property (
        settled && cfg_r[5] && !cfg_r[7] && com_lcd_o == 4'hF
        |-> com_pin_o[1] == com_pin_o[0] && com_pin_o[3] == com_pin_o[2]
            && (cfg_r[6] || com_pin_o[2] == com_pin_o[0]))
        else $error("parallel commons differ");
    a_com_nonsel: assert property (
        settled && cfg_r[7:5] == 3'h5 && com_lcd_o[3] |-> !com_pin_o[3])
        else $error("fourth common selected at third duty");
    a_standby_dark: assert property (
        stb_r == 3'h7 |-> !lcd_m_o && (com_pin_o & com_lcd_o) == 4'h0)
        else $error("display still driven in standby");
    a_shift_pulse: assert property (
        settled && expansion_select_bit && $rose(seg_pin_o[38]) |=> clk_rest)
        else $error("shift clock high longer than one cycle");
    a_latch_pulse: assert property (
        settled && expansion_select_bit && $rose(seg_pin_o[39]) |=> !seg_pin_o[39])
        else $error("latch clock high longer than one cycle");
    a_alt_pin: assert property (
        settled && expansion_select_bit && $stable(lcd_m_o) && $stable(seg_pin_o[36])
        |-> seg_pin_o[36] == lcd_m_o)
        else $error("polarity pin differs from polarity signal");
    a_one_common: assert property (
        settled && !cfg_r[5] |-> $onehot0(com_pin_o & com_lcd_o))
        else $error("more than one common selected");
endmodule : sldc_props
bind sldc_top sldc_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .standby_i(standby_i),
    .seg_port_i(seg_port_i), .seg_pin_o(seg_pin_o), .seg_lcd_o(seg_lcd_o),
    .com_pin_o(com_pin_o), .com_lcd_o(com_lcd_o), .lcd_m_o(lcd_m_o));
`default_nettype wire

// ### tb/sldc_exp_model.sv
// external segment expansion driver: counts shifted bits between latches
`timescale 1ns/10ps
`default_nettype none
module sldc_exp_model (
    input  wire logic        clk_i,
    input  wire logic [39:0] seg_pin_i,
    output logic      [8:0]  bits_o,
    output logic      [15:0] per_o,
    output logic      [7:0]  latches_o,
    output logic      [8:0]  ones_o
);
    logic [8:0]  cnt_r = 9'h000;
    logic [8:0]  one_r = 9'h000;
    logic [7:0]  lat_r = 8'h00;
    logic [15:0] len_r = 16'h0000;
    logic [1:0]  prv_r = 2'h0;
    // edges are taken on the pins, so internal pin lag is harmless
    wire         shift_up = seg_pin_i[38] & ~prv_r[0];
    wire         latch_up = seg_pin_i[39] & ~prv_r[1];
    assign latches_o = lat_r;
    always @(posedge clk_i) begin
        prv_r <= seg_pin_i[39:38];
        cnt_r <= latch_up ? 9'h000 : cnt_r + {8'h00, shift_up};
        one_r <= latch_up ? 9'h000
               : one_r + {8'h00, shift_up & seg_pin_i[37]};
        len_r <= latch_up ? 16'h0001 : len_r + 16'h0001;
        if (latch_up) begin
            bits_o    <= cnt_r;
            per_o     <= len_r;
            ones_o    <= one_r;
            lat_r     <= lat_r + 8'h01;
        end
    end
endmodule : sldc_exp_model
`default_nettype wire

// ### tb/tb_sldc_top.sv
// self-checking bench of the segment lcd duty and pin block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    mismatches++; $display("unexpected %s exp %0h seen %0h", n, e, g); end end
module tb_sldc_top;
    localparam int PB = 1600;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [17:0] adr = 18'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic        we = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        standby = 1'b0;
    logic [39:0] seg_port = 40'h13_5724_6809;
    logic [3:0]  com_port = 4'h5;
    logic [31:0] dat_o, r;
    logic        ack, lcd_m;
    logic [39:0] seg_pin, seg_lcd;
    logic [3:0]  com_pin, com_lcd;
    logic [8:0]  bits, ones;
    logic [15:0] per;
    logic [7:0]  latches;
    logic [8:0]  nexp [4] = '{sldc_pkg::EXP_SEGS_STAT,
        sldc_pkg::EXP_SEGS_HALF, sldc_pkg::EXP_SEGS_QUAD,
        sldc_pkg::EXP_SEGS_QUAD};
    int          mismatches = 0;
    int          checked = 0;
    initial forever #12.5 clk_i = ~clk_i;
    // moving port values so a stuck port path cannot pass
    always @(posedge clk_i) begin
        seg_port <= {seg_port[38:0], ~seg_port[39]};
        com_port <= {com_port[2:0], ~com_port[3]};
    end
    sldc_top #(.PHASE_BASE(PB)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .standby_i(standby),
        .seg_port_i(seg_port), .com_port_i(com_port), .seg_pin_o(seg_pin),
        .seg_lcd_o(seg_lcd), .com_pin_o(com_pin), .com_lcd_o(com_lcd),
        .lcd_m_o(lcd_m));
    sldc_exp_model u_exp (.clk_i(clk_i), .seg_pin_i(seg_pin), .bits_o(bits),
        .per_o(per), .latches_o(latches), .ones_o(ones));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic wb(input logic [15:0] idx, input logic w,
                      input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        adr  <= {idx, 2'h0};
        we   <= w;
        wdat <= d;
        sel  <= s;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            complete_run();
        end
        @(posedge clk_i);
    endtask : wb
    task automatic wait_latch(input int k);
        logic [7:0] l0;
        int         n;
        l0 = latches;
        n = 0;
        while (8'(latches - l0) < k && n < 40000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 40000) begin
            mismatches++;
            complete_run();
        end
    endtask : wait_latch
    function automatic logic [3:0] com_exp(input logic [7:0] c);
        if (!c[4] && c[3:0] == 4'h0)
            return 4'h0;
        return c[5] ? 4'hF : 4'hF >> (2'h3 - c[7:6]);
    endfunction : com_exp
    function automatic logic [39:0] seg_exp(input logic [7:0] c);
        logic [3:0] g;
        g = c[3] ? 4'h9 + {3'h0, c[0]}
                 : c[3:0] + {3'h0, (c[3:0] != 4'h0) | c[4]};
        return ~(40'hFF_FFFF_FFFF >> {g, 2'h0});
    endfunction : seg_exp
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(sldc_pkg::IDX_PIN_CFG, 1'b0, 32'h0, 4'h1);
        `CHK("pin cfg reset", 32'h00, r)
        wb(sldc_pkg::IDX_CTRL, 1'b0, 32'h0, 4'h1);
        `CHK("ctrl reset", 32'h80, r)
        wb(sldc_pkg::IDX_RAM_FIRST, 1'b1, 32'hA55A, 4'h3);
        wb(sldc_pkg::IDX_RAM_FIRST + 16'h1, 1'b1, 32'h77, 4'h1);
        wb(sldc_pkg::IDX_RAM_LAST, 1'b1, 32'h96, 4'h1);
        wb(sldc_pkg::IDX_RAM_FIRST, 1'b0, 32'h0, 4'h3);
        `CHK("ram word", 32'h775A, r)
        wb(sldc_pkg::IDX_RAM_LAST, 1'b0, 32'h0, 4'h1);
        `CHK("ram last", 32'h96, r)
        wb(16'hF780, 1'b0, 32'h0, 4'h1);
        `CHK("past ram end", 32'h0, r)
        // every pin config value, commons and segment groups settle
        for (int c = 0; c < 256; c++) begin
            wb(sldc_pkg::IDX_PIN_CFG, 1'b1, 32'(c), 4'h1);
            repeat (8) @(posedge clk_i);
            `CHK("com_lcd", com_exp(8'(c)), com_lcd)
            `CHK("seg_lcd", seg_exp(8'(c)), seg_lcd)
        end
        wb(sldc_pkg::IDX_PIN_CFG, 1'b0, 32'h0, 4'h1);
        `CHK("pin cfg readback", 32'hFF, r)
        // all-ones display ram makes every lcd and serial data bit known
        for (int i = 0; i < sldc_pkg::RAM_DEPTH; i++)
            wb(sldc_pkg::IDX_RAM_FIRST + 16'(i), 1'b1, 32'hFF, 4'h1);
        `CHK("seg data", 40'h0F_FFFF_FFFF, seg_pin & 40'h0F_FFFF_FFFF)
        for (int d = 3; d >= 0; d--) begin
            wb(sldc_pkg::IDX_PIN_CFG, 1'b1, {24'h0, 2'(d), 6'h10}, 4'h1);
            wait_latch(2);
            `CHK("expansion bits", nexp[d], bits)
            `CHK("expansion data", nexp[d], ones)
        end
        // display off above the third rate keeps phases short
        for (int f = 0; f < 11; f++) begin
            wb(sldc_pkg::IDX_CTRL, 1'b1, 32'(f) | (f < 3 ? 32'h80 : 0), 4'h1);
            wb(sldc_pkg::IDX_CTRL, 1'b0, 32'h0, 4'h1);
            `CHK("ctrl", 32'(f) | (f < 3 ? 32'h80 : 0), r)
            if (f < 3) begin
                wait_latch(2);
                `CHK("phase length", 16'(PB << f), per)
            end
        end
        wb(sldc_pkg::IDX_CTRL, 1'b1, 32'h80, 4'h1);
        standby <= 1'b1;
        repeat (10) @(posedge clk_i);
        `CHK("m in standby", 1'b0, lcd_m)
        `CHK("com in standby", 4'h0, com_pin & com_lcd)
        wb(sldc_pkg::IDX_STATUS, 1'b0, 32'h0, 4'h1);
        `CHK("run in standby", 1'b0, r[2])
        standby <= 1'b0;
        wait_latch(1);
        wb(sldc_pkg::IDX_STATUS, 1'b0, 32'h0, 4'h1);
        `CHK("run after standby", 1'b1, r[2])
        complete_run();
    end
endmodule : tb_sldc_top
`default_nettype wire
